// >>> rtl/sbsr_pkg.sv
package sbsr_pkg;

  // Status word layout
  localparam int STAT_W = 8;
  localparam int BIT_ERR = 0;
  localparam int BIT_STOP = 1;
  localparam int BIT_START = 2;
  localparam int BIT_FAIL = 3;
  localparam int BIT_ZERO = 4;
  localparam int BIT_SWEEP = 5;
  localparam int BIT_RQS = 6;
  localparam int BIT_BUSY = 7;
  localparam int FLAG_W = 4;

  // Reset values
  localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;
  localparam logic [FLAG_W-1:0] MASK_RST = 4'h0;
  localparam logic [STAT_W-1:0] STAT_RST = 8'h00;

  // Condition inputs grouped together
  typedef struct packed {
    logic err;
    logic sweep_stop;
    logic sweep_start;
    logic fault;
  } sbsr_cond_t;

  // Clear sources grouped together
  typedef struct packed {
    logic serial_poll;
    logic status_query_cmd;
    logic bus_clear;
    logic reset_cmd;
    logic panel_preset;
  } sbsr_clr_t;

endpackage : sbsr_pkg

// >>> rtl/sbsr_edge.sv
`timescale 1ns/10ps
// Two-stage synchroniser with rising-edge pulse per bit
module sbsr_edge #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] lvl_i,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] lvl_o
);

  logic [W-1:0] meta_reg; // First stage, read only by second
  logic [W-1:0] sync_reg; // Stable synchronised level
  logic [W-1:0] prev_reg; // Previous level for edge detect

  // Synchroniser and history
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= lvl_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Held-high level gives no pulse, only the false-to-true change
  assign rise_o = sync_reg & ~prev_reg;
  assign lvl_o = sync_reg;

endmodule : sbsr_edge

// >>> rtl/sbsr_top.sv
`timescale 1ns/10ps
module sbsr_top (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic ERR_EVT_I,
  input wire logic SWEEP_DONE_I,
  input wire logic SWEEP_STOP_CMD_I,
  input wire logic SWEEP_START_I,
  input wire logic SELF_TEST_FAIL_I,
  input wire logic CAL_FAIL_I,
  input wire logic REF_UNLOCK_I,
  input wire logic OSC_UNLOCK_I,
  input wire logic MEM_LOST_I,
  input wire logic SWEEP_RUN_I,
  input wire logic CMD_BUSY_I,
  input wire logic SERIAL_POLL_I,
  input wire logic STATUS_QUERY_CMD_I,
  input wire logic BUS_CLEAR_I,
  input wire logic RESET_CMD_I,
  input wire logic PANEL_PRESET_I,
  input wire logic MASK_SET_CMD_I,
  input wire logic [3:0] MASK_DATA_I,
  output logic [7:0] STATUS_WORD_O,
  output logic STATUS_VALID_O,
  output logic SRQ_N_O,
  output logic SRQ_LED_O,
  output logic [3:0] MASK_O
);

  localparam int NSRC = 8; // Edge-detected sources
  localparam int NLVL = 2; // Live level sources
  localparam int NCTL = 6; // Strobe inputs

  // Strobe positions in the synchronised strobe vector
  localparam int CTL_POLL = 0;
  localparam int CTL_QUERY = 1;
  localparam int CTL_BCLR = 2;
  localparam int CTL_RCMD = 3;
  localparam int CTL_PRESET = 4;
  localparam int CTL_MASK = 5;

  // Latency: a pin level sampled at one edge reaches the decode one edge
  // later and the registered state one edge after that. The extra cycles
  // are the price of taking board signals from other timing safely, so a
  // controller that polls right after a condition rises may read the old word.
  // Strobes therefore need two cycles high and one low to be seen reliably.

  logic [NSRC-1:0] src_lvl; // Raw condition pins
  logic [NSRC-1:0] src_rise; // One-cycle rising pulses
  logic [NLVL-1:0] lvl_meta_reg; // Live bit first stage
  logic [NLVL-1:0] lvl_sync_reg; // Live bit second stage
  logic [NCTL-1:0] ctl_meta_reg; // Strobe first stage
  logic [NCTL-1:0] ctl_sync_reg; // Strobe second stage
  logic [NCTL-1:0] ctl_prev_reg; // Strobe edge history
  logic [3:0] mdat_meta_reg; // Mask data first stage
  logic [3:0] mdat_sync_reg; // Mask data second stage
  logic [NCTL-1:0] ctl_rise; // Strobe pulses

  sbsr_pkg::sbsr_cond_t set_evt; // Per-flag set events
  sbsr_pkg::sbsr_clr_t clr_evt; // Clear sources
  logic mask_wr; // Mask write strobe

  logic [sbsr_pkg::FLAG_W-1:0] flags_reg; // Latched flags bits 0..3
  logic [sbsr_pkg::FLAG_W-1:0] flags_next;
  logic [sbsr_pkg::FLAG_W-1:0] mask_reg; // Service request mask
  logic [sbsr_pkg::FLAG_W-1:0] mask_next;
  logic rqs_reg; // Bit 6 require service
  logic rqs_next;
  logic [sbsr_pkg::STAT_W-1:0] stat_reg; // Captured answer word
  logic [sbsr_pkg::STAT_W-1:0] stat_next;
  logic valid_reg; // Answer valid pulse
  logic srq_n_reg; // Bus request line, active low
  logic led_reg; // Front panel request indicator

  logic [sbsr_pkg::FLAG_W-1:0] set_vec; // Set events as vector
  logic [sbsr_pkg::FLAG_W-1:0] new_flags; // Unmasked flags newly rising now
  logic [sbsr_pkg::FLAG_W-1:0] clr_flags; // Flags to drop
  logic [sbsr_pkg::FLAG_W-1:0] stop_clr; // Extra clears from sweep events
  logic [sbsr_pkg::STAT_W-1:0] live_word; // Word as it stands now
  logic read_evt; // Poll or query answered
  logic rqs_clr; // Any bit 6 clear source
  logic rqs_set; // Qualified new set event

  assign src_lvl = {MEM_LOST_I, OSC_UNLOCK_I, REF_UNLOCK_I, CAL_FAIL_I,
                    SELF_TEST_FAIL_I, SWEEP_START_I, SWEEP_STOP_CMD_I | SWEEP_DONE_I, ERR_EVT_I};

  // Sources come from other logic on the board, so synchronise and take edges
  sbsr_edge #(
    .W(NSRC)
  ) u_edge (
    .clk_i(CLK_SYS_I),
    .nrst_i(NRST_I),
    .lvl_i(src_lvl),
    .rise_o(src_rise),
    .lvl_o() // Levels unused: flags act on edges only
  );

  // Live bits and strobes pass two flip-flops
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lvl_meta_reg <= '0;
      lvl_sync_reg <= '0;
      ctl_meta_reg <= '0;
      ctl_sync_reg <= '0;
      ctl_prev_reg <= '0;
      mdat_meta_reg <= '0;
      mdat_sync_reg <= '0;
    end else begin
      lvl_meta_reg <= {CMD_BUSY_I, SWEEP_RUN_I};
      lvl_sync_reg <= lvl_meta_reg;
      ctl_meta_reg <= {MASK_SET_CMD_I, PANEL_PRESET_I, RESET_CMD_I, BUS_CLEAR_I,
                       STATUS_QUERY_CMD_I, SERIAL_POLL_I};
      ctl_sync_reg <= ctl_meta_reg;
      ctl_prev_reg <= ctl_sync_reg;
      mdat_meta_reg <= MASK_DATA_I;
      mdat_sync_reg <= mdat_meta_reg;
    end
  end

  // Strobes act once per assertion
  // A strobe held high acts once; it must drop before it acts again,
  // which keeps a slow controller from clearing twice on one request
  assign ctl_rise = ctl_sync_reg & ~ctl_prev_reg;
  assign clr_evt.serial_poll = ctl_rise[CTL_POLL];
  assign clr_evt.status_query_cmd = ctl_rise[CTL_QUERY];
  assign clr_evt.bus_clear = ctl_rise[CTL_BCLR];
  assign clr_evt.reset_cmd = ctl_rise[CTL_RCMD];
  assign clr_evt.panel_preset = ctl_rise[CTL_PRESET];
  assign mask_wr = ctl_rise[CTL_MASK];

  // Fault is any of five hardware conditions rising
  assign set_evt.err = src_rise[0];
  assign set_evt.sweep_stop = src_rise[1];
  assign set_evt.sweep_start = src_rise[2];
  assign set_evt.fault = |src_rise[7:3];
  // Vector order matches status bits 0 to 3
  assign set_vec = {set_evt.fault, set_evt.sweep_start, set_evt.sweep_stop, set_evt.err};

  // Live word: bit 4 fixed zero, bits 5 and 7 pure levels
  assign live_word = {lvl_sync_reg[1], rqs_reg, lvl_sync_reg[0], 1'b0, flags_reg};

  // Poll and query read the same captured word
  // A poll and a query in one cycle count as a single read
  assign read_evt = clr_evt.serial_poll | clr_evt.status_query_cmd;

  // Sweep start drops stopped; stop drops started
  assign stop_clr = {1'b0, set_evt.sweep_stop, set_evt.sweep_start, 1'b0};

  // Only flags visible in the captured answer are cleared by the read
  assign clr_flags = (read_evt ? flags_reg : '0) | stop_clr;

  // Set beats clear so a simultaneous event is not lost
  assign flags_next = (flags_reg & ~clr_flags) | set_vec;

  // Only a fresh set event qualifies, never a stale flag unmasked later
  assign new_flags = set_vec & mask_reg;
  assign rqs_set = |new_flags;
  // Bit 6 and the request line move together: the line is the registered
  // inverse of the next bit 6, so both change on one edge
  assign rqs_clr = read_evt | clr_evt.bus_clear | clr_evt.reset_cmd | clr_evt.panel_preset;
  assign rqs_next = rqs_set | (rqs_reg & ~rqs_clr);

  // Mask is four bits wide; busy and sweep bits cannot be enabled
  // Mask data has its own two stages; it must stay steady around the strobe
  assign mask_next = mask_wr ? mdat_sync_reg : mask_reg;

  // Answer word held from capture until the next read
  assign stat_next = read_evt ? live_word : stat_reg;

  // Flag, mask and bit 6 state
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      flags_reg <= sbsr_pkg::FLAGS_RST;
      mask_reg <= sbsr_pkg::MASK_RST;
      rqs_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      mask_reg <= mask_next;
      rqs_reg <= rqs_next;
    end
  end

  // Answer and request outputs, all registered
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      stat_reg <= sbsr_pkg::STAT_RST;
      valid_reg <= 1'b0;
      srq_n_reg <= 1'b1;
      led_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      valid_reg <= read_evt;
      srq_n_reg <= ~rqs_next;
      led_reg <= rqs_next;
    end
  end

  // Top outputs are plain copies of flops
  assign STATUS_WORD_O = stat_reg;
  assign STATUS_VALID_O = valid_reg;
  assign SRQ_N_O = srq_n_reg;
  assign SRQ_LED_O = led_reg;
  assign MASK_O = mask_reg;

endmodule : sbsr_top

// >>> bench/sbsr_props.sv
`timescale 1ns/10ps
// Watches the status word logic at the top ports
module sbsr_props (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic SERIAL_POLL_I,
  input wire logic STATUS_QUERY_CMD_I,
  input wire logic BUS_CLEAR_I,
  input wire logic MASK_SET_CMD_I,
  input wire logic [3:0] MASK_DATA_I,
  input wire logic [7:0] STATUS_WORD_O,
  input wire logic STATUS_VALID_O,
  input wire logic SRQ_N_O,
  input wire logic SRQ_LED_O,
  input wire logic [3:0] MASK_O
);
  default clocking dc @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  // Answer lands three edges after the strobe is seen
  sequence s_answer;
    ##3 STATUS_VALID_O;
  endsequence
  AST_POLL: assert property ($rose(SERIAL_POLL_I) |-> s_answer ##0 SRQ_N_O)
    else $error("poll gave no answer");
  AST_QUERY: assert property ($rose(STATUS_QUERY_CMD_I) |-> s_answer)
    else $error("query gave no answer");
  AST_PULSE: assert property (STATUS_VALID_O |=> !STATUS_VALID_O)
    else $error("valid longer than one cycle");
  AST_STAND: assert property (!STATUS_VALID_O |-> $stable(STATUS_WORD_O))
    else $error("word moved without valid");
  AST_LED: assert property (SRQ_LED_O == !SRQ_N_O)
    else $error("indicator disagrees with request");
  AST_BIT4: assert property (STATUS_VALID_O |-> !STATUS_WORD_O[4])
    else $error("bit 4 not zero");
  AST_CLR: assert property ($rose(BUS_CLEAR_I) |-> ##3 SRQ_N_O)
    else $error("bus clear kept request");
  AST_MASK: assert property ($rose(MASK_SET_CMD_I) |-> ##3 MASK_O == $past(MASK_DATA_I, 3))
    else $error("mask not written");
  AST_RST: assert property ($rose(NRST_I) |-> SRQ_N_O && MASK_O == 4'h0)
    else $error("reset state wrong");
endmodule : sbsr_props
bind sbsr_top sbsr_props u_props (.CLK_SYS_I, .NRST_I, .SERIAL_POLL_I, .STATUS_QUERY_CMD_I, .BUS_CLEAR_I,
  .MASK_SET_CMD_I, .MASK_DATA_I, .STATUS_WORD_O, .STATUS_VALID_O, .SRQ_N_O, .SRQ_LED_O, .MASK_O);

// >>> bench/sbsr_ctrl_model.sv
`timescale 1ns/10ps
// Bus controller side: issues serial polls, reads the word
module sbsr_ctrl_model (
  input wire logic clk_i,
  input wire logic [7:0] word_i,
  input wire logic valid_i,
  output logic poll_o
);
  initial poll_o = 1'b0;
  // Strobe two cycles so the sync sees it, then bounded wait
  task automatic poll(output logic [7:0] w, output bit ok);
    ok = 1'b0;
    @(negedge clk_i) poll_o = 1'b1;
    repeat (2) @(negedge clk_i);
    poll_o = 1'b0;
    for (int i = 0; i < 6 && !ok; i++) begin
      @(negedge clk_i);
      ok = (valid_i === 1'b1);
      w = word_i;
    end
  endtask : poll
endmodule : sbsr_ctrl_model

// >>> bench/testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("ERROR %0t %h %h", $time, a, b); end end
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] sv = 16'h0000; // Condition and strobe levels
  logic [3:0] mdat = 4'h0;
  logic poll, valid, srq_n, led;
  logic [7:0] word;
  logic [3:0] mask;
  int failures = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  sbsr_top u_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .ERR_EVT_I(sv[0]), .SWEEP_DONE_I(sv[1]), .SWEEP_STOP_CMD_I(sv[2]),
    .SWEEP_START_I(sv[3]), .SELF_TEST_FAIL_I(sv[4]), .CAL_FAIL_I(sv[5]), .REF_UNLOCK_I(sv[6]), .OSC_UNLOCK_I(sv[7]),
    .MEM_LOST_I(sv[8]), .SWEEP_RUN_I(sv[9]), .CMD_BUSY_I(sv[10]), .SERIAL_POLL_I(poll), .STATUS_QUERY_CMD_I(sv[11]),
    .BUS_CLEAR_I(sv[12]), .RESET_CMD_I(sv[13]), .PANEL_PRESET_I(sv[14]), .MASK_SET_CMD_I(sv[15]),
    .MASK_DATA_I(mdat), .STATUS_WORD_O(word), .STATUS_VALID_O(valid), .SRQ_N_O(srq_n), .SRQ_LED_O(led), .MASK_O(mask));
  sbsr_ctrl_model u_ctrl (.clk_i(clk), .word_i(word), .valid_i(valid), .poll_o(poll));
  task automatic wrap_up;
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Two cycles high, then room for the sync latency
  task automatic pulse(input int b);
    @(negedge clk) sv[b] = 1'b1;
    repeat (2) @(negedge clk);
    sv[b] = 1'b0;
    repeat (4) @(negedge clk);
  endtask : pulse
  task automatic mset(input logic [3:0] m);
    mdat = m;
    pulse(15);
    `CHK(mask, m)
  endtask : mset
  // Poll and judge word; a lost answer ends the run
  task automatic pchk(input logic [7:0] e);
    logic [7:0] w;
    bit ok;
    u_ctrl.poll(w, ok);
    if (!ok) begin
      failures++;
      wrap_up();
    end
    `CHK(w, e)
    `CHK(srq_n, 1'b1)
    `CHK(led, 1'b0)
  endtask : pchk
  // Held condition sets once only
  task automatic t_err;
    mset(4'hF);
    sv[0] = 1'b1;
    repeat (5) @(negedge clk);
    `CHK(led, 1'b1)
    pchk(8'h41);
    pchk(8'h00);
    sv[0] = 1'b0;
    for (int b = 4; b < 9; b++) begin
      pulse(b);
      pchk(8'h48);
    end
  endtask : t_err
  // Start and stop clear each other
  task automatic t_sweep;
    pulse(3);
    pulse(1);
    pchk(8'h42);
    pulse(3);
    pulse(2);
    pchk(8'h42);
    pulse(1);
    pulse(3);
    pchk(8'h44);
  endtask : t_sweep
  // Flag set while masked stays silent when unmasked
  task automatic t_mask;
    mset(4'h0);
    pulse(0);
    mset(4'h1);
    `CHK(srq_n, 1'b1)
    pchk(8'h01);
    mset(4'h2);
    pulse(0);
    `CHK(srq_n, 1'b1)
    pulse(1);
    `CHK(srq_n, 1'b0)
    pchk(8'h43);
  endtask : t_mask
  // Clears drop request but keep flags; query reads and clears
  task automatic t_clr;
    mset(4'hF);
    for (int b = 12; b < 15; b++) begin
      pulse(0);
      pulse(b);
      `CHK(srq_n, 1'b1)
    end
    pulse(11);
    `CHK(word, 8'h01)
    // Query and a new error in one cycle: word is pre-clear, the error stays
    @(negedge clk) sv[11] = 1'b1;
    sv[0] = 1'b1;
    repeat (2) @(negedge clk);
    sv[11] = 1'b0;
    sv[0] = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(word, 8'h00)
    `CHK(srq_n, 1'b0)
    sv[9] = 1'b1;
    sv[10] = 1'b1;
    pchk(8'hE1);
  endtask : t_clr
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    `CHK(mask, 4'h0)
    `CHK(srq_n, 1'b1)
    t_err();
    t_sweep();
    t_mask();
    t_clr();
    wrap_up();
  end
endmodule : testbench
